// ==== design/reload_down_counter_timer.sv ====
// 16-bit reload down-counter timer core with trigger, gate and event count operation
//
// Behaviour
// - any clock select other than 111 counts prescaler ticks.
// - clock select 111 counts the chosen edges of the timer input pin.
// - with run enable set, a software kick starts the count.
// - in external trigger operation a chosen edge on the input pin starts the count.
// - in external gate operation the count advances only while the pin holds the chosen level.
// - in reload mode an underflow from 0000 reloads the counter and counting goes on.
// - in reload mode every underflow without a start in the same cycle raises an interrupt request.
// - in one-shot mode the underflow raises an interrupt request.
// - in one-shot mode the output pin shows a pulse spanning the running interval.
// - the output toggles on each underflow without a same-cycle start and reaches the pin only while drive is enabled.
// - the counter value output always shows the live count.
// - the reload value is loaded into the counter at each start and, in reload mode only, on underflow; one-shot underflow loads ffff.
// - the count clock is the prescaler tick or the input pin, by clock mode.
// - with drive enable set the output pin is driven whatever the port direction.
`timescale 1ns/1ps
module reload_down_counter_timer
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // configuration
    input wire logic [2:0] clock_select,
    input wire logic [2:0] trigger_mode,
    input wire logic counter_run_enable,
    input wire logic pin_drive_enable,
    input wire logic output_invert,
    input wire logic reload_mode,
    input wire logic [15:0] reload_value,
    // one-cycle start request from software
    input wire logic software_kick,
    // timer pins
    input wire logic timer_input_pin,
    output logic timer_output_pin,
    output logic timer_output_oe,
    // status
    output logic [15:0] counter_value,
    output logic running,
    output logic underflow_irq
);

    reload_timer_pkg::timer_cfg_s cfg;
    reload_timer_pkg::timer_state_s q;
    reload_timer_pkg::timer_state_s d;

    logic pin_level;
    logic pin_rise;
    logic pin_fall;
    logic prescale_tick;
    logic event_mode;
    logic gate_mode;
    logic trig_mode;
    logic in_edge;
    logic gate_ok;
    logic gate_edge;
    logic start;
    logic tick;
    logic count_en;
    logic uf;

    assign cfg = '{
        clock_select: clock_select,
        trigger_mode: trigger_mode,
        counter_run_enable: counter_run_enable,
        pin_drive_enable: pin_drive_enable,
        output_invert: output_invert,
        reload_mode: reload_mode,
        reload_value: reload_value
    };

    pin_edge_detect u_pin
    (
        .clk(clk),
        .arst_n(arst_n),
        .pin_in(timer_input_pin),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    count_prescaler u_prescale
    (
        .clk(clk),
        .arst_n(arst_n),
        .clock_select(cfg.clock_select),
        .tick(prescale_tick)
    );

    // operation decode
    assign event_mode = cfg.clock_select == reload_timer_pkg::CSEL_EVENT;
    assign gate_mode = !event_mode && cfg.trigger_mode[reload_timer_pkg::TMODE_GATE_BIT];
    assign trig_mode = !event_mode && !cfg.trigger_mode[reload_timer_pkg::TMODE_GATE_BIT]
        && cfg.trigger_mode[1:0] != reload_timer_pkg::TMODE_NO_EDGE;
    assign in_edge = reload_timer_pkg::edge_hit(cfg.trigger_mode[1:0], pin_rise, pin_fall);
    assign gate_ok = pin_level == cfg.trigger_mode[reload_timer_pkg::TMODE_LEVEL_BIT];
    // the pin entering its valid level
    assign gate_edge = cfg.trigger_mode[reload_timer_pkg::TMODE_LEVEL_BIT] ? pin_rise : pin_fall;

    // start sources; a kick in gate mode also restarts
    assign start = cfg.counter_run_enable && (software_kick
        || (trig_mode && in_edge)
        || (gate_mode && gate_edge && q.st == reload_timer_pkg::ST_IDLE));

    // count clock source
    assign tick = event_mode ? in_edge : prescale_tick;
    assign count_en = q.st == reload_timer_pkg::ST_RUN && tick && (!gate_mode || gate_ok);
    assign uf = count_en && q.cnt == reload_timer_pkg::CNT_ZERO;

    always_comb
    begin
        d = q;
        d.irq = 1'b0;
        d.oe = cfg.pin_drive_enable;
        case (q.st)
            reload_timer_pkg::ST_IDLE:
            begin
                if (start)
                begin
                    d.st = reload_timer_pkg::ST_RUN;
                    d.cnt = cfg.reload_value;
                    d.tout = cfg.output_invert ^ !cfg.reload_mode;
                end
            end
            reload_timer_pkg::ST_RUN:
            begin
                if (start)
                begin
                    d.cnt = cfg.reload_value;
                    d.tout = cfg.output_invert ^ !cfg.reload_mode;
                end
                else if (uf)
                begin
                    d.irq = 1'b1;
                    d.tout = ~q.tout;
                    if (cfg.reload_mode)
                    begin
                        d.cnt = cfg.reload_value;
                    end
                    else
                    begin
                        d.cnt = reload_timer_pkg::CNT_UNDERFLOW;
                        d.st = reload_timer_pkg::ST_IDLE;
                    end
                end
                else if (count_en)
                begin
                    d.cnt = q.cnt - 16'h0001;
                end
            end
            default:
            begin
                d.st = reload_timer_pkg::ST_IDLE;
            end
        endcase
        // clearing run enable goes idle on the next edge; a tick in that same cycle still decrements or underflows the count
        if (!cfg.counter_run_enable)
        begin
            d.st = reload_timer_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            q <= '{st: reload_timer_pkg::ST_IDLE, cnt: reload_timer_pkg::CNT_RESET,
                tout: 1'b0, oe: 1'b0, irq: 1'b0};
        end
        else
        begin
            q <= d;
        end
    end

    assign counter_value = q.cnt;
    assign running = q.st == reload_timer_pkg::ST_RUN;
    assign timer_output_pin = q.tout;
    assign timer_output_oe = q.oe;
    assign underflow_irq = q.irq;

    // prescaled count decrements by exactly one
    property p_internal_count;
        @(posedge clk) disable iff (!arst_n)
        (!event_mode && running && prescale_tick && !start && !gate_mode && counter_run_enable
            && counter_value != 16'h0000)
        |=> counter_value == $past(counter_value) - 16'h0001;
    endproperty
    a_internal_count: assert property (p_internal_count)
        else $error("prescaled count did not decrement by one");

    // event mode: no selected edge, no change
    property p_event_hold;
        @(posedge clk) disable iff (!arst_n)
        (event_mode && running && !in_edge && !start && counter_run_enable)
        |=> $stable(counter_value);
    endproperty
    a_event_hold: assert property (p_event_hold)
        else $error("event count moved without an input edge");

    // event mode: selected edge decrements
    property p_event_count;
        @(posedge clk) disable iff (!arst_n)
        (event_mode && running && in_edge && !start && counter_run_enable
            && counter_value != 16'h0000)
        |=> counter_value == $past(counter_value) - 16'h0001;
    endproperty
    a_event_count: assert property (p_event_count)
        else $error("event count did not follow the input edge");

    // kick with run enable loads the reload value and runs
    property p_kick_start;
        @(posedge clk) disable iff (!arst_n)
        (counter_run_enable && software_kick)
        |=> running && counter_value == $past(reload_value);
    endproperty
    a_kick_start: assert property (p_kick_start)
        else $error("software kick did not start the count with the reload value");

    // external edge starts
    property p_trigger_start;
        @(posedge clk) disable iff (!arst_n)
        (counter_run_enable && trig_mode && in_edge) |=> running;
    endproperty
    a_trigger_start: assert property (p_trigger_start)
        else $error("valid trigger edge did not start the count");

    // gate closed holds the count
    property p_gate_hold;
        @(posedge clk) disable iff (!arst_n)
        (gate_mode && !gate_ok && running && !start && counter_run_enable)
        |=> $stable(counter_value);
    endproperty
    a_gate_hold: assert property (p_gate_hold)
        else $error("count moved while the gate level was invalid");

    // reload on underflow keeps running
    property p_reload;
        @(posedge clk) disable iff (!arst_n)
        (uf && reload_mode && counter_run_enable && !start)
        |=> running && counter_value == $past(reload_value);
    endproperty
    a_reload: assert property (p_reload)
        else $error("underflow did not reload the counter");

    // each underflow gives one request pulse
    property p_irq;
        @(posedge clk) disable iff (!arst_n)
        (uf && !start) |=> underflow_irq ##1 (!underflow_irq || $past(uf && !start));
    endproperty
    a_irq: assert property (p_irq)
        else $error("underflow did not raise a request pulse");

    // output toggles on underflow
    property p_toggle;
        @(posedge clk) disable iff (!arst_n)
        (uf && !start) |=> timer_output_pin != $past(timer_output_pin);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("timer output did not invert on underflow");

    // one-shot start drives the active output level
    property p_oneshot_pulse;
        @(posedge clk) disable iff (!arst_n)
        (start && !reload_mode) |=> timer_output_pin == !$past(output_invert);
    endproperty
    a_oneshot_pulse: assert property (p_oneshot_pulse)
        else $error("one-shot start did not raise the output pulse");

    // drive enable follows one cycle later
    property p_drive;
        @(posedge clk) disable iff (!arst_n)
        ##1 timer_output_oe == $past(pin_drive_enable);
    endproperty
    a_drive: assert property (p_drive)
        else $error("pin drive did not follow its enable");

    // one-shot underflow stops and stays stopped without a trigger
    property p_oneshot_stop;
        @(posedge clk) disable iff (!arst_n)
        (uf && !reload_mode && !start) |=> !running ##1 (running -> $past(start));
    endproperty
    a_oneshot_stop: assert property (p_oneshot_stop)
        else $error("one-shot counter did not stay idle after underflow");

    // dropping run enable leaves the counter idle on the next edge
    property p_run_stop;
        @(posedge clk) disable iff (!arst_n)
        !counter_run_enable
        |=> !running;
    endproperty
    a_run_stop: assert property (p_run_stop)
        else $error("counter kept running without run enable");

    // open gate lets a prescaled tick decrement by one
    property p_gate_count;
        @(posedge clk) disable iff (!arst_n)
        (gate_mode && gate_ok && running && prescale_tick && !start && counter_run_enable
            && counter_value != 16'h0000)
        |=> counter_value == $past(counter_value) - 16'h0001;
    endproperty
    a_gate_count: assert property (p_gate_count)
        else $error("count did not advance while the gate level was valid");

    // an idle counter only changes through a start
    property p_idle_hold;
        @(posedge clk) disable iff (!arst_n)
        (!running && !start)
        |=> $stable(counter_value);
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("idle counter changed without a start");

endmodule : reload_down_counter_timer

// ==== design/reload_timer_pkg.sv ====
// shared constants, codes and carrier types of the reload down-counter timer
package reload_timer_pkg;

    // clock select: this code picks event counting on the input pin
    localparam logic [2:0] CSEL_EVENT = 3'h7;
    localparam int CSEL_W = 3;

    // trigger mode field: bit 2 picks gate operation
    localparam int TMODE_GATE_BIT = 2;
    // edge operation: bit 0 rising, bit 1 falling; 00 means software kick only
    localparam int TMODE_RISE_BIT = 0;
    localparam int TMODE_FALL_BIT = 1;
    // gate operation: bit 0 set means the high level is the valid level
    localparam int TMODE_LEVEL_BIT = 0;
    localparam logic [1:0] TMODE_NO_EDGE = 2'h0;

    // counter width, reset value and the value after an underflow
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_UNDERFLOW = 16'hffff;

    // prescaler: select n divides the system clock by 2 to the power n+1
    localparam int PRESCALE_W = 7;
    localparam logic [6:0] PRESCALE_RESET = 7'h00;
    localparam logic [6:0] PRESCALE_ONE = 7'h01;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_RUN = 2'h2
    } run_state_e;

    // software-facing configuration
    typedef struct packed {
        logic [2:0] clock_select;
        logic [2:0] trigger_mode;
        logic counter_run_enable;
        logic pin_drive_enable;
        logic output_invert;
        logic reload_mode;
        logic [15:0] reload_value;
    } timer_cfg_s;

    // complete state of the timer core
    typedef struct packed {
        run_state_e st;
        logic [15:0] cnt;
        logic tout;
        logic oe;
        logic irq;
    } timer_state_s;

    // state of the input pin conditioner
    typedef struct packed {
        logic pin;
        logic prev;
    } pin_state_s;

    // state of the prescaler
    typedef struct packed {
        logic [6:0] div;
        logic tick;
    } prescale_state_s;

    // selected edge found on the input pin
    function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
        edge_hit = (sel[TMODE_RISE_BIT] & rise) | (sel[TMODE_FALL_BIT] & fall);
    endfunction : edge_hit

    // low n+1 bits set, for divide ratio 2^(n+1)
    function automatic logic [6:0] prescale_mask(input logic [2:0] sel);
        prescale_mask = 7'((PRESCALE_ONE << (sel + 3'h1)) - PRESCALE_ONE);
    endfunction : prescale_mask

endpackage : reload_timer_pkg

// ==== design/pin_edge_detect.sv ====
// input pin sampler with rising and falling edge detection
`timescale 1ns/1ps
module pin_edge_detect
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // pin
    input wire logic pin_in,
    // conditioned view
    output logic level,
    output logic rise,
    output logic fall
);

    reload_timer_pkg::pin_state_s q;
    reload_timer_pkg::pin_state_s d;

    always_comb
    begin
        d = q;
        d.pin = pin_in;
        d.prev = q.pin;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign level = q.pin;
    assign rise = q.pin & ~q.prev;
    assign fall = ~q.pin & q.prev;

endmodule : pin_edge_detect

// ==== design/count_prescaler.sv ====
// free-running prescaler giving one tick per selected division of the system clock
`timescale 1ns/1ps
module count_prescaler
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // division select
    input wire logic [2:0] clock_select,
    // one-cycle count tick
    output logic tick
);

    reload_timer_pkg::prescale_state_s q;
    reload_timer_pkg::prescale_state_s d;

    always_comb
    begin
        d = q;
        d.div = q.div + reload_timer_pkg::PRESCALE_ONE;
        d.tick = &(q.div | ~reload_timer_pkg::prescale_mask(clock_select));
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            q <= '{div: reload_timer_pkg::PRESCALE_RESET, tick: 1'b0};
        end
        else
        begin
            q <= d;
        end
    end

    assign tick = q.tick;

endmodule : count_prescaler

// ==== bench/timer_far_side.sv ====
// far side model: pulse source on the input pin and load on the output pin
`timescale 1ns/1ps
module timer_far_side
(
    // clock
    input wire logic clk,
    // timer output side
    input wire logic tout,
    input wire logic oe,
    // pin levels
    output logic pin_out,
    output logic line
);
    initial pin_out = 1'b0;
    initial line = 1'b0;
    // undriven line keeps changing so a stale value cannot pass
    always @(posedge clk)
        line <= oe ? tout : ~line;
    // the input pin is only ever driven from here, as a port input
    task automatic level(input logic v);
        @(posedge clk);
        pin_out <= v;
    endtask : level
    task automatic pulse(input int n);
        repeat (n)
        begin
            level(1'b1);
            repeat (2) @(posedge clk);
            level(1'b0);
            repeat (2) @(posedge clk);
        end
        @(negedge clk);
    endtask : pulse
endmodule : timer_far_side

// ==== bench/tb_reload_down_counter_timer.sv ====
// self-checking bench for the reload down-counter timer
`timescale 1ns/1ps
module tb_reload_down_counter_timer;
    typedef struct packed {
        logic [15:0] cnt;
        logic tout;
        logic run;
    } note_s;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] clock_select = 3'h0;
    logic [2:0] trigger_mode = 3'h0;
    logic counter_run_enable = 1'b0;
    logic pin_drive_enable = 1'b0;
    logic output_invert = 1'b0;
    logic reload_mode = 1'b0;
    logic [15:0] reload_value = 16'h0002;
    logic software_kick = 1'b0;
    logic timer_input_pin;
    logic timer_output_pin;
    logic timer_output_oe;
    logic [15:0] counter_value;
    logic running;
    logic underflow_irq;
    logic pin_line;
    int fails = 0;
    int checks_done = 0;
    note_s notes[$];
    logic exp_out = 1'b0;
    logic [15:0] held;

    always #20 clk = ~clk;

    reload_down_counter_timer DUT (.clk(clk), .arst_n(arst_n), .clock_select(clock_select),
        .trigger_mode(trigger_mode), .counter_run_enable(counter_run_enable),
        .pin_drive_enable(pin_drive_enable), .output_invert(output_invert),
        .reload_mode(reload_mode), .reload_value(reload_value), .software_kick(software_kick),
        .timer_input_pin(timer_input_pin), .timer_output_pin(timer_output_pin),
        .timer_output_oe(timer_output_oe), .counter_value(counter_value), .running(running),
        .underflow_irq(underflow_irq));

    timer_far_side u_far (.clk(clk), .tout(timer_output_pin), .oe(timer_output_oe),
        .pin_out(timer_input_pin), .line(pin_line));

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk16

    task automatic chk1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    // start level: polarity flipped in one-shot so the run shows as a pulse
    task automatic kick();
        @(posedge clk);
        software_kick <= 1'b1;
        @(posedge clk);
        software_kick <= 1'b0;
        exp_out = output_invert ^ ~reload_mode;
        @(negedge clk);
    endtask : kick

    task automatic expect_uf();
        note_s n;
        exp_out = ~exp_out;
        n.cnt = reload_mode ? reload_value : 16'hffff;
        n.tout = exp_out;
        n.run = reload_mode;
        notes.push_back(n);
    endtask : expect_uf

    task automatic drain(input int lim);
        for (int i = 0; i < lim && notes.size() != 0; i++)
            @(posedge clk);
        chk16(16'(notes.size()), 16'h0000);
        notes.delete();
        @(negedge clk);
    endtask : drain

    // every interrupt pulse must match the oldest note
    always @(negedge clk)
    begin
        if (underflow_irq === 1'b1)
        begin
            chk16(16'(notes.size() != 0), 16'h0001);
            if (notes.size() != 0)
            begin
                chk16(counter_value, notes[0].cnt);
                chk1(timer_output_pin, notes[0].tout);
                chk1(running, notes[0].run);
                void'(notes.pop_front());
            end
        end
    end

    initial
    begin
        #(40 * 20000);
        fails++;
        conclude();
    end

    initial
    begin
        void'($urandom(32'h8e859890));
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        settle(1);
        chk16(counter_value, 16'h0000);
        chk1(running, 1'b0);
        chk1(timer_output_oe, 1'b0);
        @(posedge clk);
        clock_select <= 3'($urandom_range(0, 2));
        reload_value <= 16'($urandom_range(2, 5));
        output_invert <= 1'($urandom_range(0, 1));
        reload_mode <= 1'b1;
        counter_run_enable <= 1'b1;
        pin_drive_enable <= 1'b1;
        kick();
        chk16(counter_value, reload_value);
        chk1(running, 1'b1);
        chk1(timer_output_pin, exp_out);
        expect_uf();
        expect_uf();
        drain(2000);
        @(posedge clk);
        counter_run_enable <= 1'b0;
        settle(2);
        chk1(running, 1'b0);
        kick();
        chk1(running, 1'b0);
        $display("test internal reload done");
        @(posedge clk);
        clock_select <= reload_timer_pkg::CSEL_EVENT;
        reload_mode <= 1'b0;
        reload_value <= 16'h0002;
        counter_run_enable <= 1'b1;
        for (int m = 1; m <= 3; m++)
        begin
            @(posedge clk);
            trigger_mode <= 3'(m);
            kick();
            expect_uf();
            u_far.pulse(m == 3 ? 2 : 3);
            drain(200);
            chk16(counter_value, 16'hffff);
        end
        $display("test event count done");
        @(posedge clk);
        clock_select <= 3'h0;
        trigger_mode <= 3'h2;
        counter_run_enable <= 1'b0;
        reload_value <= 16'h0003;
        u_far.pulse(1);
        settle(2);
        chk1(running, 1'b0);
        @(posedge clk);
        counter_run_enable <= 1'b1;
        exp_out = ~output_invert;
        u_far.pulse(1);
        settle(2);
        chk1(running, 1'b1);
        chk1(timer_output_pin, exp_out);
        expect_uf();
        drain(200);
        $display("test external trigger done");
        @(posedge clk);
        trigger_mode <= 3'h5;
        reload_value <= 16'h0010;
        u_far.level(1'b1);
        settle(4);
        chk1(running, 1'b1);
        exp_out = ~output_invert;
        chk1(timer_output_pin, exp_out);
        u_far.level(1'b0);
        settle(3);
        held = counter_value;
        settle(8);
        chk16(counter_value, held);
        expect_uf();
        u_far.level(1'b1);
        drain(400);
        // low-level gate: the pin falling opens the gate
        @(posedge clk);
        trigger_mode <= 3'h4;
        reload_value <= 16'h0004;
        exp_out = ~output_invert;
        expect_uf();
        u_far.level(1'b0);
        drain(200);
        $display("test gate done");
        @(posedge clk);
        pin_drive_enable <= 1'b0;
        settle(2);
        chk1(timer_output_oe, 1'b0);
        @(posedge clk);
        pin_drive_enable <= 1'b1;
        settle(2);
        chk1(timer_output_oe, 1'b1);
        chk1(pin_line, timer_output_pin);
        $display("test pin drive done");
        conclude();
    end
endmodule : tb_reload_down_counter_timer
